// ---- rtl/dwell_timer.sv ----
`timescale 1ns/1ps
// ==============================
// millisecond dwell timer
module dwell_timer #(
    parameter int CYCLES_PER_MS = pt_pkg::CYCLES_PER_MS
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [14:0] i_ms,
    output logic o_done
);
    import pt_pkg::*;

    localparam int CW = $clog2(CYCLES_PER_MS + 1);

    // elaboration check: a millisecond needs at least one cycle
    if (CYCLES_PER_MS < 1) begin : g_bad_param
        $error("dwell_timer: CYCLES_PER_MS must be at least 1");
    end

    logic running; // timer active
    logic [14:0] ms_left; // whole ms still to wait
    logic [CW-1:0] cyc; // cycles inside the current ms

    wire last_cyc = (cyc == CW'(CYCLES_PER_MS - 1));
    wire last_ms = (ms_left <= 15'h0001);

    // ==============================
    // countdown; a start while running restarts it
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            running <= 1'b0;
            ms_left <= 15'h0000;
            cyc <= '0;
            o_done <= 1'b0;
        end else if (i_start) begin
            running <= 1'b1;
            ms_left <= i_ms;
            cyc <= '0;
            o_done <= 1'b0;
        end else begin
            o_done <= running && last_cyc && last_ms; // one-cycle pulse
            if (running && last_cyc) begin
                cyc <= '0;
                ms_left <= ms_left - 15'h0001;
                running <= !last_ms;
            end else if (running) begin
                cyc <= cyc + CW'(1);
            end
        end
    end

endmodule : dwell_timer

// ---- rtl/point_table_positioning_sequencer.sv ----
`timescale 1ns/1ps
// Function
// - select bits form binary entry number 1..255
// - one station: only five low bits used
// - two stations: register may select entry
// - position held signed, clamped to +-999999
// - incremental negative position commands reverse rotation
// - accel and decel fields clamp 0..20000 ms
// - dwell and aux ignored for register selection
// - nonzero dwell: finish, wait, start next
// - aux zero: single entry, no dwell
// - aux one, dwell zero: chain without stop
// - aux 0..3: abs/incr, single/chain
// - direction change waits for smoothed zero
// - chaining from entry 255 flags error
// - forward or reverse start begins move
module point_table_positioning_sequencer #(
    parameter int CYCLES_PER_MS = pt_pkg::CYCLES_PER_MS
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // remote input bits from the fieldbus
    input wire logic i_entry_select_bit0,
    input wire logic i_entry_select_bit1,
    input wire logic i_entry_select_bit2,
    input wire logic i_entry_select_bit3,
    input wire logic i_entry_select_bit4,
    input wire logic i_entry_select_bit5,
    input wire logic i_entry_select_bit6,
    input wire logic i_entry_select_bit7,
    input wire logic i_forward_start_bit,
    input wire logic i_reverse_start_bit,
    // motion profile generator
    input wire logic i_move_done,
    input wire logic i_smooth_zero,
    output logic o_move_valid,
    output pt_pkg::move_t o_move,
    output logic o_busy,
    output logic o_irq
);
    import pt_pkg::*;

    // ==============================
    // input synchronisers
    // the remote bits come from the fieldbus side, off this clock
    logic [9:0] pin_meta; // first stage, read only by pin_sync
    logic [9:0] pin_sync; // second stage, safe to use
    logic start_prev; // last sampled start level
    wire [9:0] pin_raw = {i_reverse_start_bit, i_forward_start_bit,
                          i_entry_select_bit7, i_entry_select_bit6, i_entry_select_bit5,
                          i_entry_select_bit4, i_entry_select_bit3, i_entry_select_bit2,
                          i_entry_select_bit1, i_entry_select_bit0};

    // two flops per pin, then the start edge memory
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            pin_meta <= 10'h000;
            pin_sync <= 10'h000;
            start_prev <= 1'b0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            start_prev <= pin_sync[8] | pin_sync[9];
        end
    end

    // ==============================
    // software registers
    logic [2:0] ctrl; // mode control
    logic [7:0] select_reg; // entry chosen by register
    logic [IRQ_W-1:0] irq_status; // sticky events
    logic [IRQ_W-1:0] irq_mask; // enables
    logic [7:0] tbl_index; // entry under edit
    entry_t table_mem [0:255]; // the point table; index 0 is never run

    // apb decode
    wire apb_access = i_psel & i_penable;
    wire apb_ack = apb_access & o_pready; // the completing edge
    wire apb_wr = apb_ack & i_pwrite;
    wire sel_ctrl = (i_paddr == OFS_CTRL);
    wire sel_select = (i_paddr == OFS_SELECT);
    wire sel_status = (i_paddr == OFS_STATUS);
    wire sel_irq_st = (i_paddr == OFS_IRQ_STATUS);
    wire sel_irq_mk = (i_paddr == OFS_IRQ_MASK);
    wire sel_index = (i_paddr == OFS_TBL_INDEX);
    wire sel_pos = (i_paddr == OFS_TBL_POS);
    wire sel_speed = (i_paddr == OFS_TBL_SPEED);
    wire sel_accel = (i_paddr == OFS_TBL_ACCEL);
    wire sel_decel = (i_paddr == OFS_TBL_DECEL);
    wire sel_dwell = (i_paddr == OFS_TBL_DWELL);
    wire sel_aux = (i_paddr == OFS_TBL_AUX);
    wire mapped = sel_ctrl | sel_select | sel_status | sel_irq_st | sel_irq_mk | sel_index
                | sel_pos | sel_speed | sel_accel | sel_decel | sel_dwell | sel_aux;

    // field clamps: no write can put an out-of-range value into the table
    wire signed [31:0] wdata_s = $signed(i_pwdata);
    wire signed [20:0] wpos = (wdata_s > 32'(POS_MAX)) ? POS_MAX :
                              (wdata_s < 32'(POS_MIN)) ? POS_MIN : i_pwdata[20:0];
    wire [14:0] wtime = (i_pwdata > 32'(TIME_MAX)) ? TIME_MAX : i_pwdata[14:0];
    entry_t edit_e; // entry under edit
    assign edit_e = table_mem[tbl_index];

    // ==============================
    // sequencer state
    state_t state; // one-hot sequencer state
    state_t next_state;
    logic [7:0] cur; // entry being run
    logic via_reg; // entry came from the select register
    logic rev_start; // run began with the reverse start
    logic cur_rev; // direction of the last issued move
    logic signed [20:0] last_target; // commanded position after last move

    // selection code
    wire [7:0] pin_code = ctrl[CTRL_TWO_STATIONS] ? pin_sync[7:0]
                                                  : {3'b000, pin_sync[4:0]};
    wire use_reg = ctrl[CTRL_REG_SELECT] & ctrl[CTRL_TWO_STATIONS];
    wire [7:0] code = use_reg ? select_reg : pin_code;
    entry_t code_e; // entry the code points at
    assign code_e = table_mem[code];
    wire start_rise = (pin_sync[8] | pin_sync[9]) & ~start_prev;
    wire code_bad = (code == ENTRY_NONE);
    // an entry 255 that asks to chain is refused at once
    wire code_chain_err = !use_reg && (code == ENTRY_LAST) && code_e.aux[AUX_CHAIN_BIT];
    wire go = (state == ST_IDLE) && start_rise && !code_bad && !code_chain_err;

    // decode of the entry being run
    entry_t cur_e;
    assign cur_e = table_mem[cur];
    // register selection ignores aux, so the mode comes from control
    wire cur_incr = via_reg ? ctrl[CTRL_REG_INCR] : cur_e.aux[AUX_INC_BIT];
    wire cur_chain = !via_reg && cur_e.aux[AUX_CHAIN_BIT];
    // incremental sign picks the direction; the reverse start flips it
    wire cur_dir = cur_incr ? (cur_e.position[20] ^ rev_start)
                            : (cur_e.position < last_target);
    wire signed [20:0] next_target = cur_incr ? 21'(last_target + cur_e.position) : cur_e.position;
    wire moved = (state == ST_MOVING) && i_move_done;
    wire chain_err = moved && cur_chain && (cur == ENTRY_LAST);
    wire chain_on = moved && cur_chain && (cur != ENTRY_LAST);
    wire go_dwell = chain_on && (cur_e.dwell_ms != 15'h0000);
    wire seq_done = moved && !cur_chain;
    wire dwell_done; // from the timer

    // ==============================
    // next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (go) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                next_state = ST_MOVING;
            end
            ST_MOVING: begin
                if (go_dwell) begin
                    next_state = ST_DWELL;
                end else if (chain_on) begin
                    next_state = ST_REVERSE;
                end else if (moved) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DWELL: begin
                if (dwell_done) begin
                    next_state = ST_REVERSE;
                end
            end
            ST_REVERSE: begin
                // same direction passes straight through, no stop
                if (cur_dir == cur_rev || i_smooth_zero) begin
                    next_state = ST_ISSUE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ==============================
    // sequencer registers
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            cur <= ENTRY_NONE;
            via_reg <= 1'b0;
            rev_start <= 1'b0;
            cur_rev <= 1'b0;
            last_target <= 21'sd0;
        end else begin
            state <= next_state;
            if (go) begin
                cur <= code;
                via_reg <= use_reg;
                rev_start <= pin_sync[9] & ~pin_sync[8];
            end else if (chain_on) begin
                cur <= cur + 8'h01;
            end
            if (state == ST_ISSUE) begin
                cur_rev <= cur_dir;
                last_target <= next_target;
            end
        end
    end

    // ==============================
    // move command towards the profile generator
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_move_valid <= 1'b0;
            o_move <= '0;
            o_busy <= 1'b0;
        end else begin
            o_move_valid <= (state == ST_ISSUE);
            o_busy <= (next_state != ST_IDLE);
            if (state == ST_ISSUE) begin
                o_move <= '{position: cur_e.position, speed: cur_e.speed,
                            accel_ms: cur_e.accel_ms, decel_ms: cur_e.decel_ms,
                            incremental: cur_incr, reverse: cur_dir, entry: cur};
            end
        end
    end

    // dwell counting lives in its own module
    dwell_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_dwell (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_start(go_dwell),
        .i_ms(cur_e.dwell_ms),
        .o_done(dwell_done)
    );

    // ==============================
    // interrupts: set wins over a same-cycle clear
    wire [IRQ_W-1:0] irq_set = {(state == ST_IDLE) && start_rise && code_bad,
                                chain_err || ((state == ST_IDLE) && start_rise && code_chain_err),
                                seq_done || chain_err};
    wire [IRQ_W-1:0] irq_clr = (apb_wr && sel_irq_st) ? i_pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            irq_status <= IRQ_RESET;
            o_irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            o_irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
        end
    end

    // ==============================
    // control register writes
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            ctrl <= CTRL_RESET;
            select_reg <= ENTRY_NONE;
            irq_mask <= IRQ_RESET;
            tbl_index <= ENTRY_NONE;
        end else if (apb_wr) begin
            if (sel_ctrl) ctrl <= i_pwdata[2:0];
            if (sel_select) select_reg <= i_pwdata[7:0];
            if (sel_irq_mk) irq_mask <= i_pwdata[IRQ_W-1:0];
            if (sel_index) tbl_index <= i_pwdata[7:0];
        end
    end

    // table writes; the table itself has no reset
    always_ff @(posedge i_mclk) begin
        if (apb_wr && sel_pos) table_mem[tbl_index].position <= wpos;
        if (apb_wr && sel_speed) table_mem[tbl_index].speed <= i_pwdata[SPEED_W-1:0];
        if (apb_wr && sel_accel) table_mem[tbl_index].accel_ms <= wtime;
        if (apb_wr && sel_decel) table_mem[tbl_index].decel_ms <= wtime;
        if (apb_wr && sel_dwell) table_mem[tbl_index].dwell_ms <= wtime;
        if (apb_wr && sel_aux) table_mem[tbl_index].aux <= i_pwdata[1:0];
    end

    // ==============================
    // read mux and apb answer
    wire [31:0] status_word = {11'h000, cur_rev, via_reg, state, cur, 5'h00, o_busy};
    wire [31:0] rd_data = sel_ctrl ? {29'h0, ctrl} :
                          sel_select ? {24'h0, select_reg} :
                          sel_status ? status_word :
                          sel_irq_st ? {29'h0, irq_status} :
                          sel_irq_mk ? {29'h0, irq_mask} :
                          sel_index ? {24'h0, tbl_index} :
                          sel_pos ? {{11{edit_e.position[20]}}, edit_e.position} :
                          sel_speed ? {16'h0, edit_e.speed} :
                          sel_accel ? {17'h0, edit_e.accel_ms} :
                          sel_decel ? {17'h0, edit_e.decel_ms} :
                          sel_dwell ? {17'h0, edit_e.dwell_ms} :
                          sel_aux ? {30'h0, edit_e.aux} : 32'h0000_0000;

    // one wait state: answer on the second access cycle
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= apb_access & ~o_pready;
            o_pslverr <= apb_access & ~o_pready & ~mapped;
            if (apb_access && !o_pready) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

endmodule : point_table_positioning_sequencer

// ---- rtl/pt_pkg.sv ----
// ==============================
// shared constants and types of the point table sequencer
package pt_pkg;

    // ==============================
    // clock and time base
    localparam int CLK_PERIOD_NS = 4; // i_mclk period
    localparam int MS_IN_NS = 1000000; // one millisecond
    localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS; // exact, no rounding needed
    localparam int TIME_MAX_MS = 20000; // longest accel, decel or dwell
    localparam int SPEED_W = 16; // speed field width, r/min

    // ==============================
    // entry numbering and value ranges
    localparam logic [7:0] ENTRY_NONE = 8'h00; // all-zero code names no entry
    localparam logic [7:0] ENTRY_LAST = 8'hff; // entry 255 has no follower
    localparam logic signed [20:0] POS_MAX = 21'sd999999; // largest position value
    localparam logic signed [20:0] POS_MIN = -21'sd999999; // smallest position value
    localparam logic [14:0] TIME_MAX = 15'(TIME_MAX_MS); // clamp for the ms fields

    // auxiliary codes: bit 1 incremental, bit 0 chained
    localparam logic [1:0] AUX_ABS_SINGLE = 2'h0;
    localparam logic [1:0] AUX_ABS_CHAIN = 2'h1;
    localparam logic [1:0] AUX_INC_SINGLE = 2'h2;
    localparam logic [1:0] AUX_INC_CHAIN = 2'h3;
    localparam int AUX_CHAIN_BIT = 0;
    localparam int AUX_INC_BIT = 1;

    // ==============================
    // register map, byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00; // mode control
    localparam logic [7:0] OFS_SELECT = 8'h04; // entry number by register
    localparam logic [7:0] OFS_STATUS = 8'h08; // sequencer state, read only
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c; // sticky events, write one to clear
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // interrupt enables
    localparam logic [7:0] OFS_TBL_INDEX = 8'h14; // table entry being edited
    localparam logic [7:0] OFS_TBL_POS = 8'h18; // position field
    localparam logic [7:0] OFS_TBL_SPEED = 8'h1c; // speed field
    localparam logic [7:0] OFS_TBL_ACCEL = 8'h20; // acceleration time field
    localparam logic [7:0] OFS_TBL_DECEL = 8'h24; // deceleration time field
    localparam logic [7:0] OFS_TBL_DWELL = 8'h28; // dwell field
    localparam logic [7:0] OFS_TBL_AUX = 8'h2c; // auxiliary field

    // control bits
    localparam int CTRL_REG_SELECT = 0; // select entry from the select register
    localparam int CTRL_TWO_STATIONS = 1; // two stations occupied
    localparam int CTRL_REG_INCR = 2; // command mode for register selection
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // interrupt bits
    localparam int IRQ_DONE = 0; // sequence finished
    localparam int IRQ_CHAIN_ERR = 1; // chain from entry 255
    localparam int IRQ_BAD_SELECT = 2; // start with code zero
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ==============================
    // types
    typedef struct packed {
        logic signed [20:0] position;
        logic [15:0] speed;
        logic [14:0] accel_ms;
        logic [14:0] decel_ms;
        logic [14:0] dwell_ms;
        logic [1:0] aux;
    } entry_t;

    typedef struct packed {
        logic signed [20:0] position;
        logic [15:0] speed;
        logic [14:0] accel_ms;
        logic [14:0] decel_ms;
        logic incremental;
        logic reverse;
        logic [7:0] entry;
    } move_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ISSUE = 5'b00010,
        ST_MOVING = 5'b00100,
        ST_DWELL = 5'b01000,
        ST_REVERSE = 5'b10000
    } state_t;

endpackage : pt_pkg

// ---- verif/point_table_positioning_sequencer_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module point_table_positioning_sequencer_tb;
    import pt_pkg::*;
    // ==============================
    // bench signals
    localparam int LAT = 5; // profile latency
    localparam int CPM = 4; // short millisecond
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, fwd = 1'b0, rev = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [7:0] sel = 8'h00; // remote code
    logic [31:0] pd = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_move_valid, o_busy, o_irq, mdone, szero;
    move_t o_move;
    int bad_count = 0, n_tests = 0, cyc = 0;
    always #2 i_mclk = ~i_mclk;
    point_table_positioning_sequencer #(.CYCLES_PER_MS(CPM)) point_table_positioning_sequencer_inst (
        .i_mclk, .i_resetn, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd),
        .o_prdata, .o_pready, .o_pslverr, .i_entry_select_bit0(sel[0]), .i_entry_select_bit1(sel[1]),
        .i_entry_select_bit2(sel[2]), .i_entry_select_bit3(sel[3]), .i_entry_select_bit4(sel[4]),
        .i_entry_select_bit5(sel[5]), .i_entry_select_bit6(sel[6]), .i_entry_select_bit7(sel[7]),
        .i_forward_start_bit(fwd), .i_reverse_start_bit(rev), .i_move_done(mdone), .i_smooth_zero(szero),
        .o_move_valid, .o_move, .o_busy, .o_irq);
    profile_model #(.LAT(LAT)) profile_model_inst (.i_mclk, .i_resetn, .i_move_valid(o_move_valid),
        .o_move_done(mdone), .o_smooth_zero(szero));
    // ==============================
    // shared tasks
    task automatic close_out();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge i_mclk);
        pen <= 1'b1;
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        q = o_prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    // one table entry, every field written
    task automatic prog(input logic [7:0] i, input logic [31:0] p, input logic [1:0] x, input logic [14:0] dw);
        wr(OFS_TBL_INDEX, {24'h0, i});
        wr(OFS_TBL_POS, p);
        wr(OFS_TBL_SPEED, 32'h64); // modest speed
        wr(OFS_TBL_ACCEL, 32'h7530); // above the clamp
        wr(OFS_TBL_DECEL, 32'ha);
        wr(OFS_TBL_DWELL, {17'h0, dw});
        wr(OFS_TBL_AUX, {30'h0, x});
    endtask : prog
    // code settles through the synchroniser before the start edge
    task automatic start(input logic [7:0] c, input logic r);
        @(posedge i_mclk);
        sel <= c;
        repeat (4) @(posedge i_mclk);
        fwd <= ~r;
        rev <= r;
    endtask : start
    task automatic wait_mv(output int n);
        n = 0;
        do begin @(posedge i_mclk); n++; end while (o_move_valid !== 1'b1 && n < 200);
    endtask : wait_mv
    task automatic idle(output int n);
        n = 0;
        while (o_busy !== 1'b0 && n < 300) begin @(posedge i_mclk); n++; end
        `CHK("idle", 1'b0, o_busy);
        @(posedge i_mclk);
        fwd <= 1'b0;
        rev <= 1'b0;
        repeat (4) @(posedge i_mclk);
    endtask : idle
    // ==============================
    // scenarios
    task automatic t_regs();
        logic [31:0] q;
        apb(1'b0, OFS_CTRL, 32'h0, q);
        `CHK("ctrl", 32'h0, q);
        apb(1'b0, 8'h40, 32'h0, q);
        `CHK("unmapped err", 1'b1, o_pslverr);
        `CHK("unmapped data", 32'h0, q);
        prog(8'h01, 32'd2000000, AUX_ABS_SINGLE, 15'h0);
        apb(1'b0, OFS_TBL_POS, 32'h0, q);
        `CHK("pos clamp", 32'd999999, q);
        apb(1'b0, OFS_TBL_ACCEL, 32'h0, q);
        `CHK("accel clamp", 32'h4e20, q);
    endtask : t_regs
    task automatic t_single();
        logic [31:0] q;
        int n;
        wr(OFS_IRQ_MASK, 32'h7);
        prog(8'h03, 32'hfffffffb, AUX_INC_SINGLE, 15'h2);
        for (int r = 0; r < 2; r++) begin
            start(8'he3, 1'(r)); // high bits dropped, one station
            wait_mv(n);
            `CHK("entry", 8'h03, o_move.entry);
            `CHK("incr", 1'b1, o_move.incremental);
            `CHK("rev", ~1'(r), o_move.reverse);
            `CHK("pos", 21'h1ffffb, o_move.position);
            `CHK("speed", 16'h64, o_move.speed);
            idle(n);
            `CHK("no dwell", 1'b1, n <= LAT + 4);
        end
        `CHK("irq", 1'b1, o_irq);
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge i_mclk);
        `CHK("irq masked", 1'b0, o_irq);
        wr(OFS_IRQ_STATUS, 32'h7);
        wr(OFS_IRQ_MASK, 32'h7);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0, q);
        `CHK("irq clear", 32'h0, q);
    endtask : t_single
    task automatic t_zero();
        logic [31:0] q;
        int n;
        start(8'h00, 1'b0);
        wait_mv(n);
        `CHK("zero code", 1'b1, n >= 200);
        idle(n);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0, q);
        `CHK("bad select", 32'h4, q);
        wr(OFS_IRQ_STATUS, 32'h7);
    endtask : t_zero
    task automatic t_chain();
        logic [31:0] q;
        int n, g1, g2, g3;
        wr(OFS_CTRL, 32'h2);
        prog(8'hfc, 32'd100, AUX_ABS_CHAIN, 15'h0);
        prog(8'hfd, 32'd200, AUX_ABS_CHAIN, 15'h2);
        prog(8'hfe, 32'd300, AUX_ABS_CHAIN, 15'h0);
        prog(8'hff, 32'd50, AUX_ABS_SINGLE, 15'h0);
        start(8'hfc, 1'b0);
        wait_mv(n);
        `CHK("first", 8'hfc, o_move.entry);
        wait_mv(g1);
        `CHK("next", 8'hfd, o_move.entry);
        `CHK("no stop", 1'b1, g1 < LAT + 2 * CPM);
        wait_mv(g2);
        `CHK("dwell", 1'b1, g2 >= g1 + 2 * CPM);
        wait_mv(g3);
        `CHK("last", 8'hff, o_move.entry);
        `CHK("turn", 1'b1, o_move.reverse);
        `CHK("turn wait", 1'b1, g3 > g1);
        idle(n);
        wr(OFS_IRQ_STATUS, 32'h7);
        wr(OFS_TBL_AUX, 32'h1); // entry 255 now chains
        start(8'hff, 1'b0);
        wait_mv(n);
        `CHK("no follower", 1'b1, n >= 200);
        idle(n);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0, q);
        `CHK("chain err", 1'b1, q[1]);
    endtask : t_chain
    task automatic t_regsel();
        int n;
        wr(OFS_CTRL, 32'h7);
        wr(OFS_SELECT, 32'hfd);
        start(8'h00, 1'b0);
        wait_mv(n);
        `CHK("reg entry", 8'hfd, o_move.entry);
        `CHK("reg mode", 1'b1, o_move.incremental);
        wait_mv(n);
        `CHK("aux ignored", 1'b1, n >= 200);
        idle(n);
    endtask : t_regsel
    // ==============================
    // hang guard and main sequence
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_regs();
        t_single();
        t_zero();
        t_chain();
        t_regsel();
        close_out();
    end
endmodule : point_table_positioning_sequencer_tb

// ---- verif/profile_model.sv ----
`timescale 1ns/1ps
// ==============================
// profile generator stand-in, done after LAT cycles
module profile_model #(
    parameter int LAT = 5
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_move_valid,
    output logic o_move_done,
    output logic o_smooth_zero
);
    logic [7:0] cnt; // cycles left in the move
    logic [3:0] tail; // smoothing lags the move end, so zero comes late
    assign o_move_done = (cnt == 8'h01);
    assign o_smooth_zero = (cnt == 8'h00) && (tail == 4'h0);
    // ==============================
    // move timing
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            cnt <= 8'h00;
            tail <= 4'h0;
        end else if (i_move_valid) begin
            cnt <= 8'(LAT);
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            tail <= 4'h3;
        end else if (tail != 4'h0) begin
            tail <= tail - 4'h1;
        end
    end
endmodule : profile_model

// ---- verif/pt_chk.sv ----
`timescale 1ns/1ps
// ==============================
// port checks of the sequencer
module pt_chk #(
    parameter int CYCLES_PER_MS = 4
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_move_valid,
    input wire pt_pkg::move_t o_move,
    input wire logic o_busy
);
    import pt_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // access phase still waiting on the slave
    sequence acc_wait; i_psel && i_penable && !o_pready; endsequence
    // one issue pulse, then quiet
    sequence issue; o_move_valid ##1 !o_move_valid; endsequence
    rdy_wait_a: assert property (acc_wait |=> o_pready) else $error("pready missing");
    rdy_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready too long");
    err_ready_a: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
    mv_pulse_a: assert property (o_move_valid |-> issue) else $error("valid too long");
    mv_hold_a: assert property (!o_move_valid |-> $stable(o_move)) else $error("move changed");
    busy_rise_a: assert property ($rose(o_busy) |=> o_move_valid) else $error("busy, no move");
    entry_nz_a: assert property (o_move_valid |-> o_move.entry != ENTRY_NONE) else $error("entry 0");
    field_range_a: assert property (o_move_valid |->
        o_move.position <= POS_MAX && o_move.position >= POS_MIN && o_move.accel_ms <= TIME_MAX
        && o_move.decel_ms <= TIME_MAX) else $error("field out of range");
endmodule : pt_chk
bind point_table_positioning_sequencer pt_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) pt_chk_inst (.i_mclk,
    .i_resetn, .i_psel, .i_penable, .o_pready, .o_pslverr, .o_move_valid, .o_move, .o_busy);
